// ==== apt_map.vh ====
// Register offsets, field positions, reset values and timing counts for the pacing controller
`ifndef APT_MAP_VH
`define APT_MAP_VH

// Register byte offsets
`define APT_CTRL_OFS 12'h000
`define APT_RANGE_OFS 12'h004
`define APT_DIV_OFS 12'h008
`define APT_LEN_OFS 12'h00C
`define APT_START_OFS 12'h010
`define APT_STATUS_OFS 12'h014
`define APT_DIGIN_OFS 12'h018
`define APT_SINGLE_OFS 12'h01C
`define APT_LIST_OFS 12'h100

// Control field positions
`define APT_CTRL_CLKSRC_BIT 0
`define APT_CTRL_TRIGSRC_BIT 1
`define APT_CTRL_VARIANT_BIT 2
`define APT_CTRL_AUTO_BIT 3

// Range field position
`define APT_RANGE_BIPOLAR_BIT 0

// List entry layout: channel in [4:0], gain code in [9:8]
`define APT_ENT_CHAN_LSB 0
`define APT_ENT_GAIN_LSB 8

// Reset values
`define APT_CTRL_RST 4'h0
`define APT_RANGE_RST 1'h1
`define APT_DIV_RST 24'h000078
`define APT_LEN_RST 6'h01

// Time base and pacing limits
`define APT_CLK_HZ 40000000
`define APT_BASE_HZ 12000000
`define APT_DIV_MAX 24'hF42400
`define APT_DIV_MIN_12 24'h000078
`define APT_DIV_MIN_G1 24'h0000F0
`define APT_DIV_MIN_G100 24'h0004B0
`define APT_DIV_MIN_G500 24'h001770
`define APT_DIGIN_CHAN 5'h10
`define APT_LIST_DEPTH 32
`define APT_LOW_CYC 4'h3

`endif

// ==== apt_list_mem.v ====
// Channel-gain list storage with registered read data
`timescale 1ns/10ps
module apt_list_mem (
  // Clock
  input wire clock_i,
  // Write port
  input wire wr_en_i,
  input wire [4:0] wr_addr_i,
  input wire [9:0] wr_data_i,
  // Read port
  input wire [4:0] rd_addr_i,
  output reg [9:0] rd_data_o
);
  // Storage array; contents undefined until software writes
  reg [9:0] mem_r [0:31];

  // Write and registered read
  always @(posedge clock_i) begin
    if (wr_en_i) begin
      mem_r[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem_r[rd_addr_i];
  end
endmodule // apt_list_mem

// ==== apt_pacing_ctrl.v ====
// Analog input pacing, triggering and channel-gain sequencing with APB registers
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/10ps
`include "apt_map.vh"
module apt_pacing_ctrl (
  // Clock and reset
  input wire clock_i,
  input wire rst_n_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // External pins
  input wire ext_sample_clock_terminal_i,
  input wire ext_trigger_terminal_i,
  input wire [7:0] port_a_i,
  // Converter side
  input wire buf_full_i,
  output reg conv_start_o,
  output reg [4:0] conv_chan_o,
  output reg [1:0] conv_gain_o,
  output reg conv_bipolar_o,
  output reg pacer_n_o,
  output reg dig_valid_o,
  output reg [7:0] dig_data_o
);
  // Machine states
  localparam ST_IDLE = 2'h0;
  localparam ST_ARM = 2'h1;
  localparam ST_RUN = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  reg [3:0] ctrl_ff; // Clock source, trigger source, variant, autorange
  reg range_bip_ff; // Subsystem-wide polarity
  reg [23:0] div_ff; // Pacing divisor in time base ticks
  reg [5:0] len_ff; // Number of list entries, 1 to 32
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [4:0] idx_ff; // Current list index
  reg [7:0] din_cap_ff; // Last digital word captured by list sequencing
  reg range_err_ff; // Sticky: rejected polarity request
  reg [1:0] auto_gain_ff; // Gain chosen by autorange
  reg sv_busy_ff; // Single-value request in flight

  // APB decode
  wire apb_wr = psel_i & penable_i & pwrite_i;
  wire list_hit = (paddr_i[11:8] == 4'h1);
  wire ctl_hit = (paddr_i[11:8] == 4'h0) & (paddr_i[7:0] <= 8'h1C) & (paddr_i[1:0] == 2'h0);
  wire is_16 = ctrl_ff[`APT_CTRL_VARIANT_BIT];
  wire start_wr = apb_wr & (paddr_i == `APT_START_OFS);
  wire stop_wr = start_wr & ~pwdata_i[0];

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  reg [1:0] eclk_sync_ff;
  reg [1:0] etrg_sync_ff;
  reg [7:0] pa_meta_ff;
  reg [7:0] pa_sync_ff;
  reg eclk_prev_ff;
  reg etrg_prev_ff;

  // Two stages per pin; only the second stage feeds the edge detectors
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      eclk_sync_ff <= 2'h0;
      etrg_sync_ff <= 2'h0;
      pa_meta_ff <= 8'h00;
      pa_sync_ff <= 8'h00;
      eclk_prev_ff <= 1'b0;
      etrg_prev_ff <= 1'b0;
    end else begin
      eclk_sync_ff <= {eclk_sync_ff[0], ext_sample_clock_terminal_i};
      etrg_sync_ff <= {etrg_sync_ff[0], ext_trigger_terminal_i};
      pa_meta_ff <= port_a_i;
      pa_sync_ff <= pa_meta_ff;
      eclk_prev_ff <= eclk_sync_ff[1];
      etrg_prev_ff <= etrg_sync_ff[1];
    end
  end

  wire eclk_rise = eclk_sync_ff[1] & ~eclk_prev_ff;
  wire etrg_rise = etrg_sync_ff[1] & ~etrg_prev_ff;

  ////////////////////////////////////////////////////////////////////////////
  // 12 MHz time base: fractional accumulator, 3 ticks every 10 clocks
  reg [5:0] tb_acc_ff;
  wire [6:0] tb_sum = {1'b0, tb_acc_ff} + 7'd12;
  wire tb_tick = (tb_sum >= 7'd40);

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tb_acc_ff <= 6'h00;
    end else if (tb_tick) begin
      tb_acc_ff <= tb_sum[5:0] - 6'd40;
    end else begin
      tb_acc_ff <= tb_sum[5:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divisor limits by variant and gain
  reg [23:0] div_min;
  always @* begin
    if (!is_16) begin
      div_min = `APT_DIV_MIN_12;
    end else if (conv_gain_o == 2'h3) begin
      div_min = `APT_DIV_MIN_G500;
    end else if (conv_gain_o == 2'h2) begin
      div_min = `APT_DIV_MIN_G100;
    end else begin
      div_min = `APT_DIV_MIN_G1;
    end
  end

  // Short divisors are raised to the minimum at use, so readback shows what was written
  wire [23:0] div_eff = (div_ff < div_min) ? div_min : div_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Internal pacing counter
  reg [23:0] pace_cnt_ff;
  reg [3:0] low_cnt_ff;
  wire running = (state_ff == ST_RUN);
  wire int_term = running & tb_tick & (pace_cnt_ff <= 24'h000001);

  // reload with divisor per terminal count
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pace_cnt_ff <= `APT_DIV_RST;
    end else if (!running) begin
      pace_cnt_ff <= div_eff;
    end else if (int_term) begin
      pace_cnt_ff <= div_eff;
    end else if (tb_tick) begin
      pace_cnt_ff <= pace_cnt_ff - 24'h000001;
    end
  end

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_cnt_ff <= 4'h0;
      pacer_n_o <= 1'b1;
    end else if (int_term & ~ctrl_ff[`APT_CTRL_CLKSRC_BIT]) begin
      low_cnt_ff <= `APT_LOW_CYC;
      pacer_n_o <= 1'b0;
    end else if (low_cnt_ff != 4'h0) begin
      low_cnt_ff <= low_cnt_ff - 4'h1;
      pacer_n_o <= (low_cnt_ff == 4'h1);
    end else begin
      pacer_n_o <= 1'b1;
    end
  end

  wire int_rise = (low_cnt_ff == 4'h1);

  wire sample_pulse = running & ~buf_full_i &
    (ctrl_ff[`APT_CTRL_CLKSRC_BIT] ? eclk_rise : int_rise);

  ////////////////////////////////////////////////////////////////////////////
  // Trigger and run state
  // software start write triggers
  wire trig_evt = ctrl_ff[`APT_CTRL_TRIGSRC_BIT] ? etrg_rise : start_wr & pwdata_i[0];

  // Next state
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start_wr & pwdata_i[0]) begin
          nxt_state = ctrl_ff[`APT_CTRL_TRIGSRC_BIT] ? ST_ARM : ST_RUN;
        end
      end
      ST_ARM: begin
        if (stop_wr) begin
          nxt_state = ST_IDLE;
        end else if (trig_evt) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (stop_wr | buf_full_i) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // State register
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // List memory and sequencing
  wire [4:0] last_idx = len_ff[4:0] - 5'h1;
  wire mem_we = apb_wr & list_hit & (paddr_i[1:0] == 2'h0);
  wire [9:0] mem_q;
  reg [9:0] wr_ent;

  // Channel legality on write: channels above 16 become the digital channel
  always @* begin
    wr_ent = {pwdata_i[9:8], 3'h0, pwdata_i[4:0]};
    if (pwdata_i[4:0] > `APT_DIGIN_CHAN) begin
      wr_ent[4:0] = `APT_DIGIN_CHAN;
    end
  end

  apt_list_mem u_list (
    .clock_i(clock_i),
    .wr_en_i(mem_we),
    .wr_addr_i(paddr_i[6:2]),
    .wr_data_i(wr_ent),
    .rd_addr_i(idx_ff),
    .rd_data_o(mem_q)
  );

  // Index advance
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      idx_ff <= 5'h00;
    end else if (!running) begin
      idx_ff <= 5'h00;
    end else if (sample_pulse) begin
      idx_ff <= (idx_ff >= last_idx) ? 5'h00 : idx_ff + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion outputs
  wire mem_dig = (mem_q[4:0] == `APT_DIGIN_CHAN);

  // Auto gain from requested range magnitude on single-value start
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      conv_start_o <= 1'b0;
      conv_chan_o <= 5'h00;
      conv_gain_o <= 2'h0;
      conv_bipolar_o <= 1'b1;
      dig_valid_o <= 1'b0;
      dig_data_o <= 8'h00;
      din_cap_ff <= 8'h00;
      sv_busy_ff <= 1'b0;
    end else begin
      conv_start_o <= 1'b0;
      dig_valid_o <= 1'b0;
      conv_bipolar_o <= range_bip_ff;
      sv_busy_ff <= 1'b0;
      if (sample_pulse) begin
        conv_chan_o <= mem_q[4:0];
        conv_gain_o <= mem_q[9:8];
        if (mem_dig) begin
          dig_valid_o <= 1'b1;
          dig_data_o <= pa_sync_ff;
          din_cap_ff <= pa_sync_ff;
        end else begin
          conv_start_o <= 1'b1;
        end
      end else if (apb_wr & (paddr_i == `APT_SINGLE_OFS) & ~running) begin
        conv_chan_o <= pwdata_i[4:0];
        conv_gain_o <= (is_16 & ctrl_ff[`APT_CTRL_AUTO_BIT]) ? auto_gain_ff : pwdata_i[9:8];
        conv_start_o <= (pwdata_i[4:0] != `APT_DIGIN_CHAN);
        dig_valid_o <= (pwdata_i[4:0] == `APT_DIGIN_CHAN);
        dig_data_o <= pa_sync_ff;
        sv_busy_ff <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_ff <= `APT_CTRL_RST;
      range_bip_ff <= `APT_RANGE_RST;
      div_ff <= `APT_DIV_RST;
      len_ff <= `APT_LEN_RST;
      range_err_ff <= 1'b0;
      auto_gain_ff <= 2'h0;
    end else if (apb_wr & ctl_hit & ~running) begin
      case (paddr_i)
        `APT_CTRL_OFS: begin
          ctrl_ff <= pwdata_i[3:0];
          // Switching to 16-bit forces bipolar
          if (pwdata_i[`APT_CTRL_VARIANT_BIT]) begin
            range_bip_ff <= 1'b1;
          end
        end
        `APT_RANGE_OFS: begin
          if (is_16 & ~pwdata_i[`APT_RANGE_BIPOLAR_BIT]) begin
            range_err_ff <= 1'b1;
          end else begin
            range_bip_ff <= pwdata_i[`APT_RANGE_BIPOLAR_BIT];
          end
          auto_gain_ff <= pwdata_i[5:4];
        end
        `APT_DIV_OFS: begin
          div_ff <= (pwdata_i[23:0] > `APT_DIV_MAX) ? `APT_DIV_MAX : pwdata_i[23:0];
        end
        `APT_LEN_OFS: begin
          // Zero or oversize lengths clamp to the legal span
          if (pwdata_i[5:0] == 6'h00) begin
            len_ff <= 6'h01;
          end else if (pwdata_i[5:0] > 6'd32) begin
            len_ff <= 6'd32;
          end else begin
            len_ff <= pwdata_i[5:0];
          end
        end
        `APT_STATUS_OFS: begin
          range_err_ff <= 1'b0;
        end
        default: begin
          range_err_ff <= range_err_ff;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB answer: one access cycle, pready asserted in the access phase
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o <= 32'h00000000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~(ctl_hit | list_hit);
      prdata_o <= 32'h00000000;
      if (psel_i & ~penable_i & ~pwrite_i) begin
        case (paddr_i)
          `APT_CTRL_OFS: prdata_o <= {28'h0000000, ctrl_ff};
          `APT_RANGE_OFS: prdata_o <= {26'h0, auto_gain_ff, 3'h0, range_bip_ff};
          `APT_DIV_OFS: prdata_o <= {8'h00, div_ff};
          `APT_LEN_OFS: prdata_o <= {26'h0, len_ff};
          `APT_STATUS_OFS: prdata_o <= {16'h0000, 3'h0, idx_ff, 3'h0, sv_busy_ff,
                                        range_err_ff, buf_full_i, state_ff};
          `APT_DIGIN_OFS: prdata_o <= {24'h000000, din_cap_ff};
          default: prdata_o <= 32'h00000000;
        endcase
      end
    end
  end

  // Reads of the list are not supported; they return zero
endmodule // apt_pacing_ctrl

// ==== apt_pacing_ctrl_sva.sv ====
// Protocol and pacing checker for the pacing controller
`timescale 1ns/10ps
module apt_pacing_ctrl_sva (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Bus side
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [11:0] paddr_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Converter side
  input wire logic buf_full_i,
  input wire logic conv_start_o,
  input wire logic [4:0] conv_chan_o,
  input wire logic pacer_n_o,
  input wire logic dig_valid_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // Setup cycle, as the slave sees it
  wire setup = psel_i && !penable_i;
  a_pready_zero_wait: assert property (setup |=> pready_o) else $error("pready late");
  a_pready_one_cycle: assert property (pready_o |=> !pready_o) else $error("pready held");
  a_slverr_with_ready: assert property (pslverr_o |-> pready_o) else $error("lone pslverr");
  a_unmapped_err: assert property (setup && paddr_i > 12'h01C && paddr_i < 12'h100
    |=> pslverr_o) else $error("unmapped not refused");
  a_start_one_cycle: assert property (conv_start_o |=> !conv_start_o) else $error("long start");
  a_pacer_low_three: assert property ($fell(pacer_n_o) |-> (!pacer_n_o)[*3] ##1 pacer_n_o)
    else $error("pacer low width");
  a_one_kind_only: assert property (!(conv_start_o && dig_valid_o)) else $error("both");
  a_digital_not_conv: assert property (conv_start_o |-> conv_chan_o != 5'h10)
    else $error("channel 16 converted");
  // Full buffer halts paced sampling once seen
  a_full_halts: assert property (buf_full_i ##1 buf_full_i |-> !conv_start_o && !dig_valid_o)
    else $error("sample while full");
  c_conv: cover property (conv_start_o);
  c_dig: cover property (dig_valid_o);
  c_err: cover property (pslverr_o);
endmodule // apt_pacing_ctrl_sva
bind apt_pacing_ctrl apt_pacing_ctrl_sva u_sva (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .buf_full_i(buf_full_i), .conv_start_o(conv_start_o),
  .conv_chan_o(conv_chan_o), .pacer_n_o(pacer_n_o), .dig_valid_o(dig_valid_o));

// ==== apt_far_model.sv ====
// External clock, trigger, digital port and buffer-full sources
`timescale 1ns/10ps
module apt_far_model (
  // Clock
  input wire logic clock_i,
  // Pins
  output logic ext_clk_o,
  output logic ext_trig_o,
  output logic [7:0] port_a_o,
  output logic buf_full_o
);
  // Idle levels; pins are low between pulses
  initial begin
    ext_clk_o = 1'b0;
    ext_trig_o = 1'b0;
    port_a_o = 8'h00;
    buf_full_o = 1'b0;
  end
  // one rising edge after an arbitrary gap
  task automatic edge_pin(input bit trig, input int gap);
    repeat (gap) @(posedge clock_i);
    if (trig) ext_trig_o <= 1'b1;
    else ext_clk_o <= 1'b1;
    // Held long enough for a two-stage synchroniser
    repeat (4) @(posedge clock_i);
    ext_trig_o <= 1'b0;
    ext_clk_o <= 1'b0;
  endtask
endmodule // apt_far_model

// ==== apt_tb.sv ====
// Self-checking bench for the pacing controller
`timescale 1ns/10ps
module tb;
  logic clock_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, rd;
  logic err, an;
  wire [31:0] prdata_o;
  wire pready_o, pslverr_o, conv_start_o, conv_bipolar_o, pacer_n_o, dig_valid_o;
  wire [4:0] conv_chan_o;
  wire [1:0] conv_gain_o;
  wire [7:0] dig_data_o, port_a;
  wire ext_clk, ext_trig, buf_full;
  int n_fail = 0, compares = 0, cyc = 0, wk;
  logic [4:0] ech [4] = '{5'h03, 5'h10, 5'h05, 5'h03};
  logic [1:0] egn [4] = '{2'h2, 2'h0, 2'h3, 2'h2};
  always #12.5 clock_i = ~clock_i;
  apt_pacing_ctrl dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .ext_sample_clock_terminal_i(ext_clk), .ext_trigger_terminal_i(ext_trig),
    .port_a_i(port_a), .buf_full_i(buf_full), .conv_start_o(conv_start_o),
    .conv_chan_o(conv_chan_o), .conv_gain_o(conv_gain_o), .conv_bipolar_o(conv_bipolar_o),
    .pacer_n_o(pacer_n_o), .dig_valid_o(dig_valid_o), .dig_data_o(dig_data_o));
  apt_far_model far (.clock_i(clock_i), .ext_clk_o(ext_clk), .ext_trig_o(ext_trig),
    .port_a_o(port_a), .buf_full_o(buf_full));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; waits for pready, no fixed latency assumed
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel_i <= 1; penable_i <= 0; pwrite_i <= wr; paddr_i <= a; pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1;
    do @(posedge clock_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask
  // Next sampling output, bounded wait
  task automatic wait_pulse();
    int k = 0;
    do begin @(posedge clock_i); k++; end
    while (conv_start_o !== 1'b1 && dig_valid_o !== 1'b1 && k < 2000);
    an = conv_start_o;
    wk = k;
    if (k >= 2000) check(0, 1);
  endtask
  task automatic results;
    if (n_fail == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin n_fail++; results(); end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clock_i);
    rst_n_i <= 1;
    apb(0, 12'h000, 0); check(rd, 0);
    apb(0, 12'h004, 0); check(rd, 1);
    apb(0, 12'h008, 0); check(rd, 32'h78);
    apb(0, 12'h040, 0); check({31'h0, err}, 1);
    check({30'h0, conv_bipolar_o, pacer_n_o}, 3);
    // List: ch3 g2, digital g0, ch5 g3; external clock, software start
    apb(1, 12'h100, 32'h203);
    apb(1, 12'h104, 32'h010);
    apb(1, 12'h108, 32'h305);
    apb(1, 12'h00C, 3); apb(1, 12'h000, 1);
    far.port_a_o <= 8'hA5;
    apb(1, 12'h010, 1);
    apb(0, 12'h014, 0); check({30'h0, rd[1:0]}, 2);
    apb(1, 12'h00C, 1); apb(0, 12'h00C, 0); check(rd, 3);
    for (int i = 0; i < 4; i++) begin
      fork far.edge_pin(0, 2 + i * 9); wait_pulse(); join
      check({31'h0, an}, {31'h0, ech[i] != 5'h10});
      if (an) check({25'h0, conv_gain_o, conv_chan_o}, {25'h0, egn[i], ech[i]});
      else check({24'h0, dig_data_o}, 32'hA5);
    end
    apb(0, 12'h018, 0); check(rd, 32'hA5);
    apb(1, 12'h010, 0);
    // External trigger arms, edge starts from first entry
    apb(1, 12'h000, 3); apb(1, 12'h010, 1);
    apb(0, 12'h014, 0); check({30'h0, rd[1:0]}, 1);
    far.edge_pin(1, 2);
    apb(0, 12'h014, 0); check({30'h0, rd[1:0]}, 2);
    fork far.edge_pin(0, 1); wait_pulse(); join
    check({27'h0, conv_chan_o}, 3);
    apb(1, 12'h010, 0);
    // Internal pacer at the 12-bit minimum divisor
    apb(1, 12'h000, 0); apb(1, 12'h00C, 1); apb(1, 12'h008, 1);
    apb(0, 12'h008, 0); check(rd, 32'h1);
    apb(1, 12'h010, 1);
    wait_pulse();
    wait_pulse(); check(wk, 400);
    far.buf_full_o <= 1'b1;
    repeat (900) @(posedge clock_i);
    apb(0, 12'h014, 0); check({29'h0, rd[2:0]}, 4);
    far.buf_full_o <= 1'b0;
    apb(1, 12'h010, 0);
    // 12-bit accepts unipolar for the whole subsystem
    apb(1, 12'h004, 0); apb(0, 12'h004, 0); check({31'h0, rd[0]}, 0);
    check({31'h0, conv_bipolar_o}, 0);
    // 16-bit variant refuses unipolar range
    apb(1, 12'h000, 4); apb(1, 12'h004, 0);
    apb(0, 12'h004, 0); check({31'h0, rd[0]}, 1);
    apb(0, 12'h014, 0); check({31'h0, rd[3]}, 1);
    check({31'h0, conv_bipolar_o}, 1);
    apb(1, 12'h014, 0); apb(0, 12'h014, 0); check({31'h0, rd[3]}, 0);
    // Autoranged single value, then a digital single value
    apb(1, 12'h000, 32'hC); apb(1, 12'h004, 32'h21);
    apb(1, 12'h01C, 32'h005); wait_pulse(); check({31'h0, an}, 1);
    check({25'h0, conv_gain_o, conv_chan_o}, {25'h0, 2'h2, 5'h05});
    far.port_a_o <= 8'h3C;
    apb(1, 12'h01C, 32'h010); wait_pulse(); check({31'h0, an}, 0);
    check({24'h0, dig_data_o}, 32'h3C);
    results();
  end
endmodule // tb
